//--- src/fsr_top.sv
// Fault and reset supervisor: reset line stretching, thermal guard, spindle sequencing, register slave
// Notes on behaviour
// - Supply undervoltage drives shared reset line low
// - Internal resets stretched by retriggerable millisecond timer
// - Clamp low, strong pull high, then weak
// - Undervoltage overrides external input, holds line low
// - Only internal causes retrigger the stretch
// - Regulator overcurrent counts as internal reset cause
// - External pulses of minimum width are accepted
// - Short supply dips filtered, long dips caught
// - Thermal limit disables the serial register port
// - Thermal entry parks head, tristates spindle drivers
// - Thermal limit releases only below hysteresis point
// - Thermal warning bit in every register read outside thermal limit (reads return zero then)
// - Report coil saturation comparator to processor
// - Park: voltage mode, ground B, park reference
// - Spindle state changes only on step edges
// - Brake pattern in start gives preload brake
// - Preload brake keeps current limiting active
// - All-zero preload tristates drivers, resets counter
`timescale 1ns/1ps
module fsr_top #(
	parameter int STRETCH_CYCLES = fsr_pkg::STRETCH_CYCLES
) (
	input wire logic MCLK,
	input wire logic RST_N,
	input wire logic [3:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	input wire logic UV_VCC,
	input wire logic UV_VDD,
	input wire logic REG_OVERCURRENT,
	input wire logic THERMAL_TRIP_POINT_HIT,
	input wire logic THERMAL_RELEASE_HYSTERESIS_CLEAR,
	input wire logic THERMAL_WARN,
	input wire logic SATURATION_THRESHOLD_INPUT,
	input wire logic COMMUTATION_STEP_CLOCK,
	input wire logic RESET_LINE_I,
	output logic RESET_LINE_O,
	output logic RESET_LINE_OE,
	output logic RESET_WEAK_PULLUP,
	output logic CHIP_RESET_N,
	output logic SPINDLE_HIZ,
	output logic COMM_COUNTER_RESET,
	output logic COMM_MUX_FROM_COUNTER,
	output logic [5:0] COMM_PATTERN,
	output logic SPINDLE_CURRENT_LIMIT_EN,
	output logic PARK_REQUEST,
	output logic VCM_VOLTAGE_MODE,
	output logic COIL_B_GROUND,
	output logic PARK_REF_SELECT,
	output logic SERIAL_PORT_OFF,
	output logic SATURATION_FLAG,
	output logic THERMAL_WARNING
);
	localparam int PULL_N = fsr_pkg::PULLUP_CYCLES;
	localparam logic [fsr_pkg::STRETCH_W-1:0] STRETCH_LOAD = fsr_pkg::STRETCH_W'(STRETCH_CYCLES - 1);
	localparam logic [fsr_pkg::PULL_W-1:0] PULL_LOAD = fsr_pkg::PULL_W'(fsr_pkg::PULLUP_CYCLES - 1);

	function automatic logic pre_zero(input logic [5:0] p);
		pre_zero = (p == 6'h00);
	endfunction

	function automatic logic [1:0] spin_code(input fsr_pkg::fsr_spin_e s);
		case (s)
			fsr_pkg::SP_Z: spin_code = 2'h0;
			fsr_pkg::SP_START: spin_code = 2'h1;
			fsr_pkg::SP_RUN: spin_code = 2'h2;
			default: spin_code = 2'h3;
		endcase
	endfunction

	// Input conditioning
	logic uv_vcc_s, uv_vdd_s, oc_s, trip_s, release_s, warn_s, sat_s, step_s, line_s;
	logic uv_f, ext_f, ext_raw, step_prev_q, step_edge;
	logic reset_line_o_q, reset_line_oe_q;

	fsr_sync #(.W(9)) u_sync (
		.clk(MCLK),
		.rst_n(RST_N),
		.d({UV_VCC, UV_VDD, REG_OVERCURRENT, THERMAL_TRIP_POINT_HIT, THERMAL_RELEASE_HYSTERESIS_CLEAR,
			THERMAL_WARN, SATURATION_THRESHOLD_INPUT, COMMUTATION_STEP_CLOCK, RESET_LINE_I}),
		.q({uv_vcc_s, uv_vdd_s, oc_s, trip_s, release_s, warn_s, sat_s, step_s, line_s})
	);

	fsr_filter #(.CYCLES(fsr_pkg::UV_FILTER_CYCLES)) u_uv_filter (
		.clk(MCLK),
		.rst_n(RST_N),
		.in(uv_vcc_s || uv_vdd_s),
		.out(uv_f)
	);

	// A low line only counts as external while this end is not pulling it low itself
	assign ext_raw = !line_s && !(reset_line_oe_q && !reset_line_o_q);
	fsr_filter #(.CYCLES(fsr_pkg::EXT_FILTER_CYCLES)) u_ext_filter (
		.clk(MCLK),
		.rst_n(RST_N),
		.in(ext_raw),
		.out(ext_f)
	);

	assign step_edge = step_s && !step_prev_q;

	// Reset line sequencer
	fsr_pkg::fsr_por_e por_st_q, por_st_d;
	logic [fsr_pkg::STRETCH_W-1:0] stretch_q, stretch_d;
	logic [fsr_pkg::PULL_W-1:0] pull_q, pull_d;
	logic internal_cause, ext_prev_q, chip_rst_n_q, chip_rst_n_d;

	assign internal_cause = uv_f || oc_s;

	always_comb begin
		por_st_d = por_st_q;
		stretch_d = stretch_q;
		pull_d = pull_q;
		if (internal_cause) begin
			por_st_d = fsr_pkg::POR_CLAMP;
			stretch_d = STRETCH_LOAD;
		end else begin
			case (por_st_q)
				fsr_pkg::POR_CLAMP: begin
					if (stretch_q == '0) begin
						por_st_d = fsr_pkg::POR_PULL;
						pull_d = PULL_LOAD;
					end else begin
						stretch_d = stretch_q - 1'b1;
					end
				end
				fsr_pkg::POR_PULL: begin
					if (pull_q == '0) begin
						por_st_d = fsr_pkg::POR_IDLE;
					end else begin
						pull_d = pull_q - 1'b1;
					end
				end
				default: por_st_d = fsr_pkg::POR_IDLE;
			endcase
		end
		chip_rst_n_d = !(por_st_d == fsr_pkg::POR_CLAMP || ext_f);
	end

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			por_st_q <= fsr_pkg::POR_CLAMP;
			stretch_q <= STRETCH_LOAD;
			pull_q <= '0;
			reset_line_o_q <= 1'b0;
			reset_line_oe_q <= 1'b1;
			chip_rst_n_q <= 1'b0;
			ext_prev_q <= 1'b0;
			step_prev_q <= 1'b0;
		end else begin
			por_st_q <= por_st_d;
			stretch_q <= stretch_d;
			pull_q <= pull_d;
			reset_line_o_q <= (por_st_d == fsr_pkg::POR_PULL);
			reset_line_oe_q <= (por_st_d != fsr_pkg::POR_IDLE);
			chip_rst_n_q <= chip_rst_n_d;
			ext_prev_q <= ext_f;
			step_prev_q <= step_s;
		end
	end

	// Register slave and software state
	logic wait_q, wait_d, req, wr_en;
	logic [31:0] rdata_q, rdata_d;
	logic start_q, start_d, en_q, en_d, park_q, park_d, ext_seen_q, ext_seen_d;
	logic [5:0] pre_q, pre_d;
	logic thermal_q, thermal_d;
	logic rw_start_q, rw_start_d, rw_pre_q, rw_pre_d, en_low_q, en_low_d, en_pulsed_q, en_pulsed_d;
	fsr_pkg::fsr_spin_e spin_q, spin_d;
	logic [31:0] status;

	assign req = AVS_READ || AVS_WRITE;
	// Writes land at the edge where the master sees waitrequest low
	assign wr_en = AVS_WRITE && !wait_q && AVS_BYTEENABLE[0] && !thermal_q;

	always_comb begin
		status = '0;
		status[fsr_pkg::STS_UV] = uv_f;
		status[fsr_pkg::STS_OVERCURRENT] = oc_s;
		status[fsr_pkg::STS_THERMAL] = thermal_q;
		status[fsr_pkg::STS_SATURATION] = sat_s;
		status[fsr_pkg::STS_CLAMP] = (por_st_q == fsr_pkg::POR_CLAMP);
		status[fsr_pkg::STS_EXT_RESET] = ext_seen_q;
		status[fsr_pkg::STS_SPIN_LO +: 2] = spin_code(spin_q);
		wait_d = !(req && wait_q);
		rdata_d = rdata_q;
		if (req && wait_q) begin
			case (AVS_ADDRESS)
				fsr_pkg::OFS_STATUS: rdata_d = status;
				fsr_pkg::OFS_SPINDLE: rdata_d = {30'h0000_0000, en_q, start_q};
				fsr_pkg::OFS_PRELOAD: rdata_d = {26'h000_0000, pre_q};
				fsr_pkg::OFS_VCM: rdata_d = {31'h0000_0000, park_q};
				default: rdata_d = 32'h0000_0000;
			endcase
			rdata_d[fsr_pkg::STS_WARN] = warn_s;
			if (thermal_q) begin
				rdata_d = 32'h0000_0000;
			end
		end
		thermal_d = thermal_q ? !release_s : trip_s;
		start_d = start_q;
		en_d = en_q;
		pre_d = pre_q;
		park_d = park_q;
		rw_start_d = rw_start_q;
		rw_pre_d = rw_pre_q;
		en_low_d = en_low_q;
		en_pulsed_d = en_pulsed_q;
		ext_seen_d = ext_seen_q;
		if (wr_en) begin
			case (AVS_ADDRESS)
				fsr_pkg::OFS_STATUS: begin
					if (AVS_WRITEDATA[fsr_pkg::STS_EXT_RESET]) begin
						ext_seen_d = 1'b0;
					end
				end
				fsr_pkg::OFS_SPINDLE: begin
					start_d = AVS_WRITEDATA[fsr_pkg::SPC_START];
					en_d = AVS_WRITEDATA[fsr_pkg::SPC_ENABLE];
					rw_start_d = 1'b1;
					if (!AVS_WRITEDATA[fsr_pkg::SPC_ENABLE]) begin
						en_low_d = 1'b1;
					end else if (en_low_q) begin
						en_pulsed_d = 1'b1;
					end
				end
				fsr_pkg::OFS_PRELOAD: begin
					pre_d = AVS_WRITEDATA[fsr_pkg::PRELOAD_W-1:0];
					rw_pre_d = 1'b1;
				end
				fsr_pkg::OFS_VCM: park_d = AVS_WRITEDATA[fsr_pkg::VCM_PARK];
				default: ;
			endcase
		end
		// Set wins over a clear in the same cycle
		if (ext_f && !ext_prev_q) begin
			ext_seen_d = 1'b1;
		end
		spin_d = spin_q;
		if (step_edge) begin
			if (spin_q != fsr_pkg::SP_Z && (thermal_q || !en_q || pre_zero(pre_q))) begin
				spin_d = fsr_pkg::SP_Z;
			end else begin
				case (spin_q)
					fsr_pkg::SP_Z: begin
						if (rw_start_q && rw_pre_q && en_pulsed_q && start_q && en_q && !pre_zero(pre_q)
							&& !thermal_q) begin
							spin_d = fsr_pkg::SP_START;
						end
					end
					fsr_pkg::SP_START: begin
						if (pre_q == fsr_pkg::PRELOAD_BRAKE) begin
							spin_d = fsr_pkg::SP_BRAKE;
						end else if (!start_q) begin
							spin_d = fsr_pkg::SP_RUN;
						end
					end
					fsr_pkg::SP_BRAKE: begin
						if (pre_q != fsr_pkg::PRELOAD_BRAKE) begin
							spin_d = fsr_pkg::SP_START;
						end
					end
					default: spin_d = spin_q;
				endcase
			end
		end
		// Tracking restarts each time tristate is entered; writes in the same cycle still land but are not tracked
		if (spin_d == fsr_pkg::SP_Z && spin_q != fsr_pkg::SP_Z) begin
			rw_start_d = 1'b0;
			rw_pre_d = 1'b0;
			en_low_d = 1'b0;
			en_pulsed_d = 1'b0;
		end
	end

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			wait_q <= 1'b1;
			rdata_q <= 32'h0000_0000;
			start_q <= fsr_pkg::RST_START;
			en_q <= fsr_pkg::RST_ENABLE;
			pre_q <= fsr_pkg::RST_PRELOAD;
			park_q <= fsr_pkg::RST_PARK;
			ext_seen_q <= 1'b0;
			thermal_q <= 1'b0;
			rw_start_q <= 1'b0;
			rw_pre_q <= 1'b0;
			en_low_q <= 1'b0;
			en_pulsed_q <= 1'b0;
			spin_q <= fsr_pkg::SP_Z;
		end else begin
			wait_q <= wait_d;
			rdata_q <= rdata_d;
			start_q <= start_d;
			en_q <= en_d;
			pre_q <= pre_d;
			park_q <= park_d;
			ext_seen_q <= ext_seen_d;
			thermal_q <= thermal_d;
			rw_start_q <= rw_start_d;
			rw_pre_q <= rw_pre_d;
			en_low_q <= en_low_d;
			en_pulsed_q <= en_pulsed_d;
			spin_q <= spin_d;
		end
	end

	// Registered outputs; thermal and zero preload tristate at once, without waiting for a step edge
	logic hiz_q, cnt_rst_q, mux_q, climit_q, park_out_q, serial_off_q, sat_q, warn_q, weak_q;
	logic [5:0] pattern_q;
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			hiz_q <= 1'b1;
			cnt_rst_q <= 1'b1;
			mux_q <= 1'b0;
			pattern_q <= 6'h00;
			climit_q <= 1'b0;
			park_out_q <= 1'b0;
			serial_off_q <= 1'b0;
			sat_q <= 1'b0;
			warn_q <= 1'b0;
			weak_q <= 1'b1;
		end else begin
			hiz_q <= spin_d == fsr_pkg::SP_Z || thermal_d || pre_zero(pre_d);
			cnt_rst_q <= pre_d != fsr_pkg::PRELOAD_ALL_ONES;
			mux_q <= pre_d == fsr_pkg::PRELOAD_ALL_ONES;
			pattern_q <= pre_d;
			climit_q <= spin_d != fsr_pkg::SP_Z;
			park_out_q <= thermal_d || park_d;
			serial_off_q <= thermal_d;
			sat_q <= sat_s;
			warn_q <= warn_s;
			weak_q <= 1'b1;
		end
	end

	assign AVS_READDATA = rdata_q;
	assign AVS_WAITREQUEST = wait_q;
	assign RESET_LINE_O = reset_line_o_q;
	assign RESET_LINE_OE = reset_line_oe_q;
	assign RESET_WEAK_PULLUP = weak_q;
	assign CHIP_RESET_N = chip_rst_n_q;
	assign SPINDLE_HIZ = hiz_q;
	assign COMM_COUNTER_RESET = cnt_rst_q;
	assign COMM_MUX_FROM_COUNTER = mux_q;
	assign COMM_PATTERN = pattern_q;
	assign SPINDLE_CURRENT_LIMIT_EN = climit_q;
	assign PARK_REQUEST = park_out_q;
	assign VCM_VOLTAGE_MODE = park_out_q;
	assign COIL_B_GROUND = park_out_q;
	assign PARK_REF_SELECT = park_out_q;
	assign SERIAL_PORT_OFF = serial_off_q;
	assign SATURATION_FLAG = sat_q;
	assign THERMAL_WARNING = warn_q;

	sequence s_clamp_end;
		por_st_q == fsr_pkg::POR_CLAMP && stretch_q == '0 && !internal_cause;
	endsequence
	sequence s_pull_phase;
		(RESET_LINE_OE && RESET_LINE_O) [*8];
	endsequence

	a_uv_clamps_line: assert property (@(posedge MCLK) disable iff (!RST_N)
		uv_f |=> RESET_LINE_OE && !RESET_LINE_O && !CHIP_RESET_N)
		else $error("undervoltage did not clamp the reset line");
	a_stretch_reload: assert property (@(posedge MCLK) disable iff (!RST_N)
		internal_cause |=> stretch_q == STRETCH_LOAD && por_st_q == fsr_pkg::POR_CLAMP)
		else $error("internal cause did not reload the stretch timer");
	// A fresh cause during the pull phase legitimately re-clamps, so it abandons the check
	a_pull_then_weak: assert property (@(posedge MCLK) disable iff (!RST_N || internal_cause)
		s_clamp_end |=> s_pull_phase ##1 !RESET_LINE_OE)
		else $error("strong pull-up phase wrong after stretch end");
	a_ext_no_stretch: assert property (@(posedge MCLK) disable iff (!RST_N)
		por_st_q == fsr_pkg::POR_IDLE && !internal_cause |=> por_st_q == fsr_pkg::POR_IDLE)
		else $error("external reset started stretching");
	a_ext_accepted: assert property (@(posedge MCLK) disable iff (!RST_N)
		ext_raw [*8] |-> ##[1:2] !CHIP_RESET_N)
		else $error("external reset pulse of minimum width not accepted");
	a_thermal_entry: assert property (@(posedge MCLK) disable iff (!RST_N)
		$rose(thermal_q) |-> SPINDLE_HIZ && PARK_REQUEST && SERIAL_PORT_OFF)
		else $error("thermal limit entry did not park and tristate");
	a_thermal_hold: assert property (@(posedge MCLK) disable iff (!RST_N)
		thermal_q && !release_s |=> thermal_q)
		else $error("thermal limit released before hysteresis point");
	a_warn_readback: assert property (@(posedge MCLK) disable iff (!RST_N)
		AVS_READ && !AVS_WAITREQUEST && !$past(thermal_q) |-> AVS_READDATA[fsr_pkg::STS_WARN] == $past(warn_s))
		else $error("thermal warning missing from readback");
	a_sat_report: assert property (@(posedge MCLK) disable iff (!RST_N)
		sat_s |=> SATURATION_FLAG)
		else $error("saturation not reported");
	a_park_mode: assert property (@(posedge MCLK) disable iff (!RST_N)
		$rose(park_q) && !thermal_q |=> VCM_VOLTAGE_MODE && COIL_B_GROUND && PARK_REF_SELECT)
		else $error("park did not switch amplifier modes");
	a_step_only: assert property (@(posedge MCLK) disable iff (!RST_N)
		!step_edge |=> $stable(spin_q))
		else $error("spindle state changed without a step edge");
	a_z_exit_guard: assert property (@(posedge MCLK) disable iff (!RST_N)
		spin_q == fsr_pkg::SP_Z && !en_pulsed_q |=> spin_q == fsr_pkg::SP_Z)
		else $error("tristate left without an enable pulse");
	a_preload_brake: assert property (@(posedge MCLK) disable iff (!RST_N)
		spin_q == fsr_pkg::SP_START && step_edge && pre_q == fsr_pkg::PRELOAD_BRAKE && en_q && !thermal_q
		|=> spin_q == fsr_pkg::SP_BRAKE ##1 SPINDLE_CURRENT_LIMIT_EN)
		else $error("preload brake mode not entered or limit off");
	a_zero_preload: assert property (@(posedge MCLK) disable iff (!RST_N)
		pre_zero(pre_q) |-> SPINDLE_HIZ && COMM_COUNTER_RESET)
		else $error("zero preload did not tristate and reset counter");
endmodule // fsr_top

//--- src/fsr_pkg.sv
// Constants, register map and state types of the fault and reset supervisor
package fsr_pkg;
	localparam int CLK_MHZ = 40;
	// Supply dip filter: longer than the dips to ignore, shorter than those to catch
	localparam int UV_FILTER_NS = 10000;
	localparam int UV_FILTER_CYCLES = (UV_FILTER_NS * CLK_MHZ + 999) / 1000;
	// External line pulse filter, kept below the least pulse width that must be taken
	localparam int EXT_MIN_NS = 300;
	localparam int EXT_FILTER_NS = 200;
	localparam int EXT_FILTER_CYCLES = (EXT_FILTER_NS * CLK_MHZ + 999) / 1000;
	localparam int FILT_W = 9;
	// Reset stretch, nominal and longest
	localparam int STRETCH_MS = 40;
	localparam int STRETCH_MAX_MS = 100;
	localparam int STRETCH_CYCLES = STRETCH_MS * CLK_MHZ * 1000;
	localparam int STRETCH_MAX_CYCLES = STRETCH_MAX_MS * CLK_MHZ * 1000;
	localparam int STRETCH_W = 22;
	// Strong pull-up drive after the stretch ends
	localparam int PULLUP_NS = 200;
	localparam int PULLUP_CYCLES = (PULLUP_NS * CLK_MHZ + 999) / 1000;
	localparam int PULL_W = 4;

	// Register byte offsets
	localparam logic [3:0] OFS_STATUS = 4'h0;
	localparam logic [3:0] OFS_SPINDLE = 4'h4;
	localparam logic [3:0] OFS_PRELOAD = 4'h8;
	localparam logic [3:0] OFS_VCM = 4'hC;
	// Status fields
	localparam int STS_UV = 0;
	localparam int STS_OVERCURRENT = 1;
	localparam int STS_THERMAL = 2;
	localparam int STS_SATURATION = 3;
	localparam int STS_CLAMP = 4;
	localparam int STS_EXT_RESET = 5;
	localparam int STS_SPIN_LO = 6;
	localparam int STS_WARN = 15;
	// Control fields
	localparam int SPC_START = 0;
	localparam int SPC_ENABLE = 1;
	localparam int VCM_PARK = 0;
	// Preload layout: high side drivers in [5:3], low side in [2:0]
	localparam int PRELOAD_W = 6;
	localparam logic [5:0] PRELOAD_ALL_ONES = 6'h3F;
	localparam logic [5:0] PRELOAD_BRAKE = 6'h07;
	// Values after reset
	localparam logic RST_START = 1'h0;
	localparam logic RST_ENABLE = 1'h0;
	localparam logic [5:0] RST_PRELOAD = 6'h00;
	localparam logic RST_PARK = 1'h0;

	typedef enum logic [1:0] {SP_Z, SP_START, SP_RUN, SP_BRAKE} fsr_spin_e;
	typedef enum logic [1:0] {POR_CLAMP, POR_PULL, POR_IDLE} fsr_por_e;
endpackage

//--- src/fsr_sync.sv
// Two-flop synchroniser for a group of asynchronous levels
`timescale 1ns/1ps
module fsr_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			logic meta_q;
			logic sync_q;
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					meta_q <= 1'b0;
					sync_q <= 1'b0;
				end else begin
					meta_q <= d[i];
					sync_q <= meta_q;
				end
			end
			assign q[i] = sync_q;
		end
	endgenerate
endmodule // fsr_sync

//--- src/fsr_filter.sv
// Glitch filter: output rises after the input has been high a set number of cycles
`timescale 1ns/1ps
module fsr_filter #(
	parameter int CYCLES = 4
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic in,
	output logic out
);
	localparam logic [fsr_pkg::FILT_W-1:0] LAST = fsr_pkg::FILT_W'(CYCLES - 1);
	logic [fsr_pkg::FILT_W-1:0] cnt_q, cnt_d;
	logic out_q, out_d;

	// Release is immediate; the comparator supplies its own hysteresis
	always_comb begin
		cnt_d = '0;
		if (in) begin
			cnt_d = (cnt_q == LAST) ? cnt_q : cnt_q + 1'b1;
		end
		out_d = in && (out_q || cnt_q == LAST);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= '0;
			out_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			out_q <= out_d;
		end
	end

	assign out = out_q;

	a_filter_min_width: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(out_q) |-> $past(cnt_q) == LAST && $past(in))
		else $error("filter output rose before the input was held long enough");
endmodule // fsr_filter

//--- bench/fsr_host.sv
// Host side of the shared reset line: board pull-up plus a tester that can pull it low
`timescale 1ns/1ps
module fsr_host (
	input wire logic drv_o,
	input wire logic drv_oe,
	input wire logic pull_low,
	output logic line
);
	// The external pull-up wins only when neither the tester nor the device drives
	assign line = pull_low ? 1'h0 : (drv_oe ? drv_o : 1'h1);
endmodule // fsr_host

//--- bench/fsr_top_tb.sv
// Self-checking bench for the fault and reset supervisor
`timescale 1ns/1ps
module fsr_top_tb;
	localparam int STR = 20;
	logic mclk = 1'h0;
	logic rst_n = 1'h0;
	logic [3:0] adr = 4'h0;
	logic rd_en = 1'h0;
	logic wr_en = 1'h0;
	logic [31:0] wdat = 32'h0000_0000;
	logic [3:0] be = 4'hF;
	logic [1:0] uv = 2'h0;
	logic ocur = 1'h0, trip = 1'h0, hclr = 1'h0, warn = 1'h0, sat = 1'h0, step = 1'h0, pull = 1'h0;
	logic [31:0] rdat;
	logic wreq, line, lo, loe, wpu, crst_n, hiz, ctr_rst, mux, lim, park, vmode, bgnd, pref, spoff, satf, warnf;
	logic [5:0] pat;
	int fail_count = 0;
	int tests_run = 0;
	int oe_cnt = 0;
	int crst_cnt = 0;

	always #12.5 mclk = ~mclk;

	// Running counts let a scenario prove that something never happened in a span
	always @(posedge mclk) begin
		oe_cnt <= oe_cnt + 32'(loe === 1'h1);
		crst_cnt <= crst_cnt + 32'(crst_n === 1'h0);
	end

	fsr_top #(.STRETCH_CYCLES(STR)) uut (.MCLK(mclk), .RST_N(rst_n), .AVS_ADDRESS(adr), .AVS_READ(rd_en),
		.AVS_WRITE(wr_en), .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(be), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wreq),
		.UV_VCC(uv[0]), .UV_VDD(uv[1]), .REG_OVERCURRENT(ocur), .THERMAL_TRIP_POINT_HIT(trip),
		.THERMAL_RELEASE_HYSTERESIS_CLEAR(hclr), .THERMAL_WARN(warn), .SATURATION_THRESHOLD_INPUT(sat),
		.COMMUTATION_STEP_CLOCK(step), .RESET_LINE_I(line), .RESET_LINE_O(lo), .RESET_LINE_OE(loe),
		.RESET_WEAK_PULLUP(wpu), .CHIP_RESET_N(crst_n), .SPINDLE_HIZ(hiz), .COMM_COUNTER_RESET(ctr_rst),
		.COMM_MUX_FROM_COUNTER(mux), .COMM_PATTERN(pat), .SPINDLE_CURRENT_LIMIT_EN(lim), .PARK_REQUEST(park),
		.VCM_VOLTAGE_MODE(vmode), .COIL_B_GROUND(bgnd), .PARK_REF_SELECT(pref), .SERIAL_PORT_OFF(spoff),
		.SATURATION_FLAG(satf), .THERMAL_WARNING(warnf));

	fsr_host host (.drv_o(lo), .drv_oe(loe), .pull_low(pull), .line(line));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask

	// One Avalon access; the request stands until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
		int n = 0;
		@(posedge mclk);
		adr <= a;
		wdat <= d;
		wr_en <= wr;
		rd_en <= !wr;
		do begin
			@(posedge mclk);
			n++;
		end while (wreq !== 1'h0 && n < 40);
		q = rdat;
		wr_en <= 1'h0;
		rd_en <= 1'h0;
		chk(32'(n < 40), 32'h0000_0001);
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'h1, a, d, x);
	endtask

	task automatic rchk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] q;
		bus(1'h0, a, 32'h0000_0000, q);
		chk(q & m, e);
	endtask

	// Waits out the stretch, the strong pull-up and the hand-back to the weak pull-up
	task automatic free_wait();
		int n = 0;
		while (lo !== 1'h1 && n < 80) begin
			@(posedge mclk);
			n++;
		end
		chk({30'h0, lo, loe}, 32'h0000_0003);
		n = 0;
		while (loe !== 1'h0 && n < 20) begin
			@(posedge mclk);
			n++;
		end
		chk({29'h0, loe, line, wpu}, 32'h0000_0003);
	endtask

	task automatic step_pulse();
		step <= 1'h1;
		cyc(4);
		step <= 1'h0;
		cyc(4);
	endtask

	task automatic final_report();
		if (fail_count == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		cyc(10000);
		fail_count++;
		$display("unexpected at %0t: timeout", $time);
		final_report();
	end

	initial begin
		int n0;
		int n1;
		cyc(2);
		chk({29'h0, loe, lo, crst_n}, 32'h0000_0004);
		cyc(6);
		rst_n <= 1'h1;
		rchk(fsr_pkg::OFS_STATUS, 32'h0000_0010, 32'h0000_0010);
		rchk(fsr_pkg::OFS_SPINDLE, 32'hFFFF_FFFF, 32'h0000_0000);
		rchk(fsr_pkg::OFS_PRELOAD, 32'hFFFF_FFFF, 32'h0000_0000);
		free_wait();
		for (int k = 0; k < 2; k++) begin
			uv[k] <= 1'h1;
			cyc(40);
			uv[k] <= 1'h0;
			n0 = oe_cnt;
			cyc(460);
			chk(32'(oe_cnt - n0), 32'h0000_0000);
			uv[k] <= 1'h1;
			pull <= k[0];
			cyc(800);
			chk({30'h0, loe, lo}, 32'h0000_0002);
			pull <= 1'h0;
			cyc(4);
			chk({31'h0, line}, 32'h0000_0000);
			uv[k] <= 1'h0;
			cyc(12);
			chk({30'h0, loe, lo}, 32'h0000_0002);
			free_wait();
		end
		ocur <= 1'h1;
		cyc(6);
		chk({31'h0, loe}, 32'h0000_0001);
		rchk(fsr_pkg::OFS_STATUS, 32'h0000_0002, 32'h0000_0002);
		ocur <= 1'h0;
		free_wait();
		wr(fsr_pkg::OFS_STATUS, 32'h0000_0020);
		rchk(fsr_pkg::OFS_STATUS, 32'h0000_0020, 32'h0000_0000);
		n0 = oe_cnt;
		n1 = crst_cnt;
		pull <= 1'h1;
		cyc(12);
		pull <= 1'h0;
		cyc(30);
		chk(32'(crst_cnt > n1), 32'h0000_0001);
		chk(32'(oe_cnt - n0), 32'h0000_0000);
		rchk(fsr_pkg::OFS_STATUS, 32'h0000_0020, 32'h0000_0020);
		trip <= 1'h1;
		cyc(5);
		chk({29'h0, spoff, park, hiz}, 32'h0000_0007);
		rchk(fsr_pkg::OFS_STATUS, 32'hFFFF_FFFF, 32'h0000_0000);
		wr(fsr_pkg::OFS_VCM, 32'h0000_0001);
		trip <= 1'h0;
		cyc(5);
		chk({31'h0, spoff}, 32'h0000_0001);
		hclr <= 1'h1;
		cyc(5);
		chk({30'h0, spoff, park}, 32'h0000_0000);
		hclr <= 1'h0;
		rchk(fsr_pkg::OFS_VCM, 32'hFFFF_FFFF, 32'h0000_0000);
		warn <= 1'h1;
		cyc(4);
		for (int j = 0; j < 4; j++)
			rchk(4'(4 * j), 32'h0000_8000, 32'h0000_8000);
		chk({31'h0, warnf}, 32'h0000_0001);
		warn <= 1'h0;
		sat <= 1'h1;
		cyc(4);
		rchk(4'h2, 32'hFFFF_FFFF, 32'h0000_0000);
		chk({31'h0, satf}, 32'h0000_0001);
		rchk(fsr_pkg::OFS_STATUS, 32'h0000_0008, 32'h0000_0008);
		sat <= 1'h0;
		wr(fsr_pkg::OFS_VCM, 32'h0000_0001);
		cyc(2);
		chk({28'h0, park, vmode, bgnd, pref}, 32'h0000_000F);
		be <= 4'h0;
		wr(fsr_pkg::OFS_VCM, 32'h0000_0000);
		be <= 4'hF;
		rchk(fsr_pkg::OFS_VCM, 32'h0000_0001, 32'h0000_0001);
		wr(fsr_pkg::OFS_VCM, 32'h0000_0000);
		wr(fsr_pkg::OFS_SPINDLE, 32'h0000_0000);
		wr(fsr_pkg::OFS_SPINDLE, 32'h0000_0003);
		wr(fsr_pkg::OFS_PRELOAD, 32'h0000_0015);
		cyc(8);
		rchk(fsr_pkg::OFS_STATUS, 32'h0000_00C0, 32'h0000_0000);
		chk({31'h0, hiz}, 32'h0000_0001);
		step_pulse();
		rchk(fsr_pkg::OFS_STATUS, 32'h0000_00C0, 32'h0000_0040);
		chk({24'h0, hiz, lim, pat}, 32'h0000_0055);
		wr(fsr_pkg::OFS_PRELOAD, 32'h0000_0007);
		step_pulse();
		rchk(fsr_pkg::OFS_STATUS, 32'h0000_00C0, 32'h0000_00C0);
		chk({30'h0, hiz, lim}, 32'h0000_0001);
		wr(fsr_pkg::OFS_PRELOAD, 32'h0000_003F);
		cyc(2);
		chk({30'h0, mux, ctr_rst}, 32'h0000_0002);
		wr(fsr_pkg::OFS_PRELOAD, 32'h0000_0000);
		cyc(2);
		chk({30'h0, hiz, ctr_rst}, 32'h0000_0003);
		final_report();
	end
endmodule // fsr_top_tb
